// *** logic/timer_pair.sv ***
// two timer/counters with 13/16-bit, 8-bit reload and split modes,
// byte-wide register port, sticky overflow flags and one interrupt line
// assumes count and gate pins are synchronous to clk

`timescale 1ns/1ns

// Summary of operation
// R01: mode 1 counts the full 16 bits of high and low bytes.
// R02: mode 2 counts low byte; overflow sets flag and reloads from high byte.
// R03: the reload never alters the high byte; only software writes do.
// R04: second timer in mode 3 holds its count as if stopped.
// R05: first timer mode 3: low byte is an 8-bit counter with own controls.
// R06: first timer mode 3: high byte times clock, runs on second run bit.
// R07: with first in mode 3, second runs unless in mode 3; overflow feeds baud.
// R08: mode codes: 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split.
// R09: counts only if run set and gate clear or gate pin high.
// R10: counter/timer select picks count pin edges or internal clock.
// R11: prescaler divides by 1, 2, 4 or 8; reset ratio is 1:2.
// R12: every rollover to zero sets its overflow flag as an interrupt request, except the second timer's while the first is in mode 3.
module timer_pair (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// register port
	input  wire logic [tc_pkg::ADDR_W-1:0]  addr,
	input  wire logic [tc_pkg::DATA_W-1:0]  wdata,
	input  wire logic                       wr,
	input  wire logic                       rd,
	output logic      [tc_pkg::DATA_W-1:0]  rdata,
	// external pins
	input  wire logic                       first_timer_count_pin,
	input  wire logic                       second_timer_count_pin,
	input  wire logic                       first_timer_gate_input,
	input  wire logic                       second_timer_gate_input,
	// interrupt and baud clock
	output logic                            irq,
	output logic                            baud_tick
);

	typedef struct packed {
		tc_pkg::mode_cfg_s cfg1;
		tc_pkg::mode_cfg_s cfg0;
		logic              first_timer_run_bit;
		logic              second_timer_run_bit;
		logic [1:0]        pre1;
		logic [1:0]        pre0;
		tc_pkg::count_s    t0;
		tc_pkg::count_s    t1;
		logic [1:0]        flags;
		logic [1:0]        mask;
		logic [7:0]        rdata;
		logic              irq;
		logic              baud;
	} regs_s;

	regs_s          q;
	regs_s          d;
	logic           tick0;
	logic           tick1;
	logic           tick_h;
	logic           split0;
	logic           en0;
	logic           en1;
	logic           inc0;
	logic           inc1;
	logic           inc_h;
	logic [8:0]     high_sum;
	logic           ovf_h;
	logic           set0;
	logic           set1;
	logic [1:0]     clr;
	tc_pkg::step_s  step0;
	tc_pkg::step_s  step1;

	////////////////////////////////////////////////////////////////////////
	// one counting step of a timer in modes 0..2, or the low half in mode 3
	function automatic tc_pkg::step_s count_step(
		input logic [1:0]     mode,
		input tc_pkg::count_s c
	);
		tc_pkg::step_s r;
		logic [5:0]    lo5;
		logic [8:0]    hi9;
		logic [8:0]    lo9;
		logic [16:0]   w17;
		r     = '0;
		r.cnt = c;
		lo5   = {1'b0, c.low[tc_pkg::MODE0_LOW_BITS-1:0]} + 6'h01;
		hi9   = {1'b0, c.high} + 9'h001;
		lo9   = {1'b0, c.low} + 9'h001;
		w17   = {1'b0, c.high, c.low} + 17'h00001;
		case (mode)
			tc_pkg::MODE_13BIT:
			begin
				// upper three low-byte bits are left as they are
				r.cnt.low[tc_pkg::MODE0_LOW_BITS-1:0] =
					lo5[tc_pkg::MODE0_LOW_BITS-1:0];
				if (lo5[tc_pkg::MODE0_LOW_BITS])
				begin
					r.cnt.high = hi9[7:0];
					r.ovf      = hi9[8];
				end
			end
			tc_pkg::MODE_16BIT:
			begin
				r.cnt.high = w17[15:8]; // R01
				r.cnt.low  = w17[7:0]; // R01
				r.ovf      = w17[16]; // R01
			end
			tc_pkg::MODE_RELOAD8:
			begin
				r.ovf     = lo9[8]; // R02
				// high byte is read only, never written back here
				r.cnt.low = lo9[8] ? c.high : lo9[7:0]; // R02 R03
			end
			default:
			begin
				r.ovf     = lo9[8]; // R05
				r.cnt.low = lo9[7:0]; // R05
			end
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// count sources; the split high half always times the internal clock
	tc_input_stage #(
		.PRE_W(3)
	) u_src0 (
		.clk    (clk),
		.rst    (rst),
		.sel    (q.pre0),
		.use_pin(q.cfg0.count_ext),
		.pin    (first_timer_count_pin),
		.tick   (tick0)
	);

	tc_input_stage #(
		.PRE_W(3)
	) u_src1 (
		.clk    (clk),
		.rst    (rst),
		.sel    (q.pre1),
		.use_pin(q.cfg1.count_ext),
		.pin    (second_timer_count_pin),
		.tick   (tick1)
	);

	tc_input_stage #(
		.PRE_W(3)
	) u_src_high (
		.clk    (clk),
		.rst    (rst),
		.sel    (q.pre0),
		.use_pin(1'b0),
		.pin    (1'b0),
		.tick   (tick_h)
	);

	////////////////////////////////////////////////////////////////////////
	// counting
	always_comb
	begin
		split0 = (q.cfg0.mode == tc_pkg::MODE_SPLIT); // R08
		en0    = q.first_timer_run_bit &
			(~q.cfg0.gate | first_timer_gate_input); // R09 R05
		// the second run bit belongs to the split high half meanwhile
		if (split0)
			en1 = (q.cfg1.mode != tc_pkg::MODE_SPLIT); // R07
		else
			en1 = q.second_timer_run_bit &
				(~q.cfg1.gate | second_timer_gate_input) &
				(q.cfg1.mode != tc_pkg::MODE_SPLIT); // R09 R04
		inc0     = en0 & tick0;
		inc1     = en1 & tick1;
		inc_h    = split0 & q.second_timer_run_bit & tick_h; // R06
		step0    = count_step(q.cfg0.mode, q.t0);
		step1    = count_step(q.cfg1.mode, q.t1);
		high_sum = {1'b0, q.t0.high} + 9'h001;
		ovf_h    = inc_h & high_sum[8]; // R06
		set0     = inc0 & step0.ovf; // R12
		set1     = split0 ? ovf_h : (inc1 & step1.ovf); // R06 R12
	end

	////////////////////////////////////////////////////////////////////////
	// next state: counting first, then software writes win; a new flag beats its clear
	always_comb
	begin
		d      = q;
		d.baud = 1'b0;
		clr    = 2'h0;

		if (inc0)
			d.t0 = step0.cnt; // R05
		if (inc_h)
			d.t0.high = high_sum[7:0]; // R06
		if (inc1)
		begin
			d.t1   = step1.cnt;
			d.baud = step1.ovf; // R07
		end

		if (wr)
		begin
			case (addr)
				tc_pkg::ADDR_MODE:
				begin
					d.cfg0 = tc_pkg::mode_cfg_s'(wdata[3:0]); // R08
					d.cfg1 = tc_pkg::mode_cfg_s'(wdata[7:4]); // R08
				end
				tc_pkg::ADDR_RUN:
				begin
					// count registers are untouched by a run change
					d.first_timer_run_bit  =
						wdata[tc_pkg::RUN_FIRST_POS]; // R09
					d.second_timer_run_bit =
						wdata[tc_pkg::RUN_SECOND_POS];
				end
				tc_pkg::ADDR_PRESCALE:
				begin
					d.pre0 = wdata[tc_pkg::PRE_FIRST_POS +: 2];
					d.pre1 = wdata[tc_pkg::PRE_SECOND_POS +: 2];
				end
				tc_pkg::ADDR_T0_LOW:  d.t0.low  = wdata;
				tc_pkg::ADDR_T0_HIGH: d.t0.high = wdata; // R03
				tc_pkg::ADDR_T1_LOW:  d.t1.low  = wdata;
				tc_pkg::ADDR_T1_HIGH: d.t1.high = wdata; // R03
				tc_pkg::ADDR_STATUS:  clr       = wdata[1:0];
				tc_pkg::ADDR_MASK:    d.mask    = wdata[1:0];
				default:              d.mask    = q.mask;
			endcase
		end

		// a flag raised in the clearing cycle survives the clear
		d.flags = q.flags & ~clr;
		if (set0)
			d.flags[tc_pkg::FLAG_FIRST_POS] = 1'b1; // R12
		if (set1)
			d.flags[tc_pkg::FLAG_SECOND_POS] = 1'b1; // R06 R12
		d.irq = |(d.flags & d.mask); // R12

		d.rdata = 8'h00;
		if (rd)
		begin
			case (addr)
				tc_pkg::ADDR_MODE:     d.rdata = {q.cfg1, q.cfg0};
				tc_pkg::ADDR_RUN:
					d.rdata = {6'h00, q.second_timer_run_bit,
						q.first_timer_run_bit};
				tc_pkg::ADDR_PRESCALE: d.rdata = {4'h0, q.pre1, q.pre0};
				tc_pkg::ADDR_T0_LOW:   d.rdata = q.t0.low;
				tc_pkg::ADDR_T0_HIGH:  d.rdata = q.t0.high;
				tc_pkg::ADDR_T1_LOW:   d.rdata = q.t1.low;
				tc_pkg::ADDR_T1_HIGH:  d.rdata = q.t1.high;
				tc_pkg::ADDR_STATUS:   d.rdata = {6'h00, q.flags};
				tc_pkg::ADDR_MASK:     d.rdata = {6'h00, q.mask};
				default:               d.rdata = 8'h00;
			endcase
		end

		if (rst)
		begin
			d         = '0;
			d.pre0    = tc_pkg::PRESCALE_RESET; // R11
			d.pre1    = tc_pkg::PRESCALE_RESET; // R11
			d.t0.low  = tc_pkg::COUNT_RESET;
			d.t0.high = tc_pkg::COUNT_RESET;
			d.t1.low  = tc_pkg::COUNT_RESET;
			d.t1.high = tc_pkg::COUNT_RESET;
			d.flags   = tc_pkg::FLAGS_RESET;
			d.mask    = tc_pkg::MASK_RESET;
		end
	end

	always_ff @(posedge clk)
		q <= d;

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	always_comb
	begin
		rdata     = q.rdata;
		irq       = q.irq;
		baud_tick = q.baud;
	end

endmodule

// *** shared/tc_pkg.sv ***
// constants, field layouts and carrier types for the dual timer/counter
// assumes one 25 MHz clock domain and a plain byte-wide register port

package tc_pkg;

	////////////////////////////////////////////////////////////////////////
	// register port geometry and map
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	localparam logic [3:0] ADDR_MODE     = 4'h0;
	localparam logic [3:0] ADDR_RUN      = 4'h1;
	localparam logic [3:0] ADDR_PRESCALE = 4'h2;
	localparam logic [3:0] ADDR_T0_LOW   = 4'h3;
	localparam logic [3:0] ADDR_T0_HIGH  = 4'h4;
	localparam logic [3:0] ADDR_T1_LOW   = 4'h5;
	localparam logic [3:0] ADDR_T1_HIGH  = 4'h6;
	localparam logic [3:0] ADDR_STATUS   = 4'h7;
	localparam logic [3:0] ADDR_MASK     = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int RUN_FIRST_POS   = 0;
	localparam int RUN_SECOND_POS  = 1;
	localparam int FLAG_FIRST_POS  = 1 - 1;
	localparam int FLAG_SECOND_POS = 1;
	localparam int PRE_FIRST_POS   = 0;
	localparam int PRE_SECOND_POS  = 2;
	localparam int MODE0_LOW_BITS  = 5;

	////////////////////////////////////////////////////////////////////////
	// mode codes and reset values
	localparam logic [1:0] MODE_13BIT   = 2'h0;
	localparam logic [1:0] MODE_16BIT   = 2'h1;
	localparam logic [1:0] MODE_RELOAD8 = 2'h2;
	localparam logic [1:0] MODE_SPLIT   = 2'h3;

	localparam logic [1:0] PRESCALE_RESET = 2'h1;
	localparam logic [7:0] COUNT_RESET    = 8'h00;
	localparam logic [1:0] FLAGS_RESET    = 2'h0;
	localparam logic [1:0] MASK_RESET     = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// carrier types
	typedef struct packed {
		logic       gate;
		logic       count_ext;
		logic [1:0] mode;
	} mode_cfg_s;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} count_s;

	typedef struct packed {
		count_s cnt;
		logic   ovf;
	} step_s;

endpackage

// *** logic/tc_input_stage.sv ***
// count source of one timer: falling-edge detect of the count pin or the
// internal clock, followed by the 1/2/4/8 prescaler
// assumes the pin is already synchronous to clk

`timescale 1ns/1ns

module tc_input_stage #(
	parameter int PRE_W = 3
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// configuration
	input  wire logic [1:0] sel,
	input  wire logic       use_pin,
	// count pin and resulting tick
	input  wire logic       pin,
	output logic            tick
);

	typedef struct packed {
		logic             pin_prev;
		logic [PRE_W-1:0] cnt;
	} stage_s;

	stage_s           q;
	stage_s           d;
	logic             ev;
	logic [PRE_W-1:0] div_mask;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d        = q;
		div_mask = PRE_W'((PRE_W'(1) << sel) - PRE_W'(1));
		// a count pin event is a high-to-low transition
		ev       = use_pin ? (q.pin_prev & ~pin) : 1'b1; // R10
		tick     = ev & ((q.cnt & div_mask) == div_mask); // R11
		d.pin_prev = pin;
		if (ev)
			d.cnt = q.cnt + PRE_W'(1);
		if (rst)
			d = '0;
	end

	always_ff @(posedge clk)
		q <= d;

endmodule

// *** tb/timer_pair_sva.sv ***
// port-level checks for the dual timer/counter
// assumes it is bound to timer_pair, one clock domain, reset synchronous
`timescale 1ns/1ns

module timer_pair_sva (
	// clock and reset
	input wire logic                      clk,
	input wire logic                      rst,
	// register port
	input wire logic [tc_pkg::ADDR_W-1:0] addr,
	input wire logic [tc_pkg::DATA_W-1:0] wdata,
	input wire logic                      wr,
	input wire logic                      rd,
	input wire logic [tc_pkg::DATA_W-1:0] rdata,
	// event outputs
	input wire logic                      irq,
	input wire logic                      baud_tick
);
	logic [7:0] mode_q;
	logic [7:0] hi_q;
	logic       hi_ok_q;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// the high byte is trusted only if no mode write followed it
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode_q  <= 8'h00;
			hi_q    <= 8'h00;
			hi_ok_q <= 1'b0;
		end
		else if (wr && addr == tc_pkg::ADDR_MODE)
		begin
			mode_q  <= wdata;
			hi_ok_q <= 1'b0;
		end
		else if (wr && addr == tc_pkg::ADDR_T0_HIGH)
		begin
			hi_q    <= wdata;
			hi_ok_q <= mode_q[1:0] == tc_pkg::MODE_RELOAD8;
		end
	end

	////////////////////////////////////////////////////////////////////
	sequence mode_written;
		wr && addr == tc_pkg::ADDR_MODE;
	endsequence
	sequence mode_read;
		rd && addr == tc_pkg::ADDR_MODE;
	endsequence

	a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside read slot");
	a_prescale_reset: assert property (
		$past(rst) && rd && addr == tc_pkg::ADDR_PRESCALE |=> rdata == 8'h05)
		else $error("prescale reset value wrong");
	a_mode_readback: assert property (
		mode_written ##2 mode_read |=> rdata == $past(wdata, 3))
		else $error("mode read back wrong");
	a_status_reserved: assert property (
		rd && addr == tc_pkg::ADDR_STATUS |=> rdata[7:2] == 6'h00)
		else $error("status reserved bits set");
	a_irq_has_flag: assert property (
		rd && addr == tc_pkg::ADDR_STATUS && irq |=> rdata[1:0] != 2'h0)
		else $error("interrupt without flag");
	a_irq_masked_off: assert property (
		wr && addr == tc_pkg::ADDR_MASK && wdata[1:0] == 2'h0 |=> !irq)
		else $error("interrupt while masked");
	a_reload_keeps_high: assert property (
		hi_ok_q && rd && addr == tc_pkg::ADDR_T0_HIGH |=> rdata == $past(hi_q))
		else $error("reload high byte changed");
	a_split_no_baud: assert property (
		mode_q[5:4] == tc_pkg::MODE_SPLIT &&
		$past(mode_q[5:4]) == tc_pkg::MODE_SPLIT |-> !baud_tick)
		else $error("stopped second timer ticked");
endmodule

// *** tb/pin_source.sv ***
// count pin model: square wave, falling edge every 2 or 4 clocks
// assumes the same clock as the timers
`timescale 1ns/1ns

module pin_source (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// pace and pin
	input  wire logic slow,
	output logic      pin
);
	logic [1:0] phase_q;

	// free-running so any window of 4k clocks holds an exact edge count
	always_ff @(posedge clk)
	begin
		if (rst)
			phase_q <= 2'h0;
		else
			phase_q <= phase_q + 2'h1;
	end
	assign pin = slow ? phase_q[1] : phase_q[0];
endmodule

// *** tb/timer_pair_tb.sv ***
// random and directed tests of the dual timer/counter
// assumes pin_source drives both count pins
`timescale 1ns/1ns

module timer_pair_tb;
	logic                      clk, rst, wr, rd, gate0, gate1, slow;
	logic                      irq, baud, pin, seen;
	logic [tc_pkg::ADDR_W-1:0] addr;
	logic [7:0]                wdata, rdata;
	logic [1:0]                m, s;
	logic [15:0]               v;
	logic [17:0]               e;
	logic [31:0]               seed;
	int                        fails, checks, n, nl;

	timer_pair DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .first_timer_count_pin(pin),
		.second_timer_count_pin(pin), .first_timer_gate_input(gate0),
		.second_timer_gate_input(gate1), .irq(irq), .baud_tick(baud));
	pin_source pins (.clk(clk), .rst(rst), .slow(slow), .pin(pin));

	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// returns {flag1, flag0, high, low} after nl low and nh high ticks
	function automatic logic [17:0] model(logic [1:0] md, logic [15:0] c,
		int nl, int nh);
		logic [17:0] r;
		logic        lw;
		r = {2'b00, c};
		repeat (nl)
		begin
			lw = md == 2'h0 ? r[4:0] == 5'h1F : r[7:0] == 8'hFF;
			if (md == 2'h0)
				r[4:0] = r[4:0] + 5'h1;
			else
				r[7:0] = r[7:0] + 8'h1;
			if (lw && md[1])
				r[16] = 1'b1;
			if (lw && md == 2'h2)
				r[7:0] = r[15:8];
			if (lw && !md[1])
				r[15:8] = r[15:8] + 8'h1;
			if (lw && !md[1] && r[15:8] == 8'h00)
				r[16] = 1'b1;
		end
		if (md == 2'h3)
			repeat (nh)
			begin
				r[15:8] = r[15:8] + 8'h1;
				r[17] = r[17] | (r[15:8] == 8'h00);
			end
		return r;
	endfunction

	task automatic chk8(string what, logic [7:0] x, logic [7:0] got);
		checks++;
		if (got !== x)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, x, got);
		end
	endtask

	task automatic wrt(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rdc(logic [3:0] a, logic [7:0] x, string what);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk8(what, x, rdata);
	endtask

	task automatic close_out;
		if (fails == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		close_out();
	end

	initial
	begin
		{rst, wr, rd, gate0, gate1, slow, addr, wdata} = {1'b1, 17'h0};
		fails = 0;
		checks = 0;
		seed = 32'h14961238;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd <= 1'b1;
		addr <= tc_pkg::ADDR_PRESCALE;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk8("prescale", 8'h05, rdata);
		for (int a = 0; a < 9; a++)
			rdc(4'(a), a == 2 ? 8'h05 : 8'h00, "reset");
		wrt(4'hF, 8'hA5);
		rdc(4'hF, 8'h00, "unmapped");
		repeat (40)
		begin
			seed = lfsr(seed);
			{m, s} = seed[3:0];
			n = 32 * (int'(seed[9:8]) + 1);
			// mode field order is {gate, count_ext}: seed[5] gates, seed[4] selects pin
			nl = seed[5] && !seed[6] ? 0 :
				(seed[4] ? n / (seed[7] ? 4 : 2) : n) >> s;
			v = {seed[28] ? 8'hFF : seed[23:16], 4'hF, seed[15:12]};
			e = model(m, v, nl, n >> s);
			@(posedge clk);
			{gate0, slow, gate1} <= {seed[6], seed[7], seed[30]};
			wrt(tc_pkg::ADDR_RUN, 8'h00);
			wrt(tc_pkg::ADDR_PRESCALE, {6'h01, s});
			wrt(tc_pkg::ADDR_MODE, {4'h3, seed[5:4], m});
			rdc(tc_pkg::ADDR_MODE, {4'h3, seed[5:4], m}, "mode");
			wrt(tc_pkg::ADDR_T0_LOW, v[7:0]);
			wrt(tc_pkg::ADDR_T0_HIGH, v[15:8]);
			wrt(tc_pkg::ADDR_T1_LOW, seed[31:24]);
			wrt(tc_pkg::ADDR_STATUS, 8'hFF);
			wrt(tc_pkg::ADDR_MASK, {6'h00, seed[11:10]});
			wrt(tc_pkg::ADDR_RUN, 8'h03);
			repeat (n - 2) @(posedge clk);
			wrt(tc_pkg::ADDR_RUN, 8'h00);
			rdc(tc_pkg::ADDR_T0_LOW, e[7:0], "low");
			rdc(tc_pkg::ADDR_T0_HIGH, e[15:8], "high");
			rdc(tc_pkg::ADDR_T1_LOW, seed[31:24], "t1 low");
			rdc(tc_pkg::ADDR_STATUS, {6'h00, e[17:16]}, "status");
			chk8("irq", {7'h00, |(e[17:16] & seed[11:10])}, {7'h00, irq});
		end
		// second timer runs while the first is in split mode, with its run bit clear
		wrt(tc_pkg::ADDR_PRESCALE, 8'h00);
		wrt(tc_pkg::ADDR_T1_LOW, 8'hFF);
		wrt(tc_pkg::ADDR_T1_HIGH, 8'hFF);
		wrt(tc_pkg::ADDR_STATUS, 8'hFF);
		wrt(tc_pkg::ADDR_MODE, 8'h13);
		seen = 1'b0;
		repeat (8)
		begin
			@(posedge clk);
			#1 seen = seen | baud;
		end
		chk8("baud", 8'h01, {7'h00, seen});
		rdc(tc_pkg::ADDR_STATUS, 8'h00, "split status");
		close_out();
	end
endmodule

bind timer_pair timer_pair_sva sva (.clk(clk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
	.baud_tick(baud_tick));
